// ==== logic/gagp_pkg.sv ====
// Graphics accelerator parameter group: offsets, reset values, field
// widths, function and panel codes, and the carrier structs.
// Assumes a 32-bit APB with one aligned word for each register.
package gagp_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_ROT       = 8'h00;
	localparam logic [7:0] OFF_COLOR     = 8'h04;
	localparam logic [7:0] OFF_SRC_LO    = 8'h08;
	localparam logic [7:0] OFF_SRC_HI    = 8'h0C;
	localparam logic [7:0] OFF_DST_LO    = 8'h10;
	localparam logic [7:0] OFF_DST_HI    = 8'h14;
	localparam logic [7:0] OFF_SRC_PITCH = 8'h18;
	localparam logic [7:0] OFF_DST_PITCH = 8'h1C;
	localparam logic [7:0] OFF_LEFT      = 8'h20;
	localparam logic [7:0] OFF_RIGHT     = 8'h24;
	localparam logic [7:0] OFF_TOP       = 8'h28;
	localparam logic [7:0] OFF_BOTTOM    = 8'h2C;
	localparam logic [7:0] OFF_CTRL      = 8'h30;
	localparam logic [7:0] OFF_DST_WIDTH = 8'h34;

	// Field widths
	localparam int unsigned ANGLE_W = 9;
	localparam int unsigned PITCH_W = 10;
	localparam int unsigned EDGE_W  = 10;
	localparam int unsigned HALF_W  = 16;

	// Angle scaling: degrees = field * 360 / 512
	localparam int unsigned DEG_FULL    = 360;
	localparam int unsigned ANGLE_STEPS = 512;

	// Values after reset
	localparam logic [8:0]  ROT_RST   = 9'h000;
	localparam logic [7:0]  COLOR_RST = 8'h03;
	localparam logic [15:0] HALF_RST  = 16'h0000;
	localparam logic [9:0]  PITCH_RST = 10'h000;
	localparam logic [9:0]  EDGE_RST  = 10'h000;
	localparam logic [7:0]  CTRL_RST  = 8'h00;

	// Control register fields
	localparam int unsigned CTRL_FUNC_LSB  = 0;
	localparam int unsigned CTRL_FILL_BIT  = 3;
	localparam int unsigned CTRL_PANEL_LSB = 4;
	localparam int unsigned CTRL_BPP_LSB   = 6;
	localparam int unsigned CTRL_OK_BIT    = 8;

	typedef enum logic [2:0] {
		FN_ROTATE_SCALE_COPY = 3'h0,
		FN_SHEAR_COPY        = 3'h1,
		FN_RECT_DRAW         = 3'h2,
		FN_LINE_DRAW         = 3'h3,
		FN_ELLIPSE_DRAW      = 3'h4,
		FN_RESERVED          = 3'h5,
		FN_SCREEN_UPDATE     = 3'h6,
		FN_ARC_DRAW_A        = 3'h7
	} gagp_func_t;

	typedef enum logic [1:0] {
		PANEL_SERIAL_BW   = 2'h0,
		PANEL_SERIAL_RGB3 = 2'h1,
		PANEL_RGB6        = 2'h2,
		PANEL_GRAY        = 2'h3
	} gagp_panel_t;

	typedef enum logic [1:0] {
		BPP_1 = 2'h0,
		BPP_2 = 2'h1,
		BPP_4 = 2'h2,
		BPP_8 = 2'h3
	} gagp_bpp_t;

	// Output window edges reported by the copy engine
	typedef struct packed {
		logic [9:0] left;
		logic [9:0] right;
		logic [9:0] top;
		logic [9:0] bottom;
	} gagp_edges_t;

	// Parameters handed to the pixel engine
	typedef struct packed {
		gagp_func_t  func;
		logic        fill_active;
		logic [7:0]  fill_color;
		logic [7:0]  pen_pixel;
		logic [1:0]  pen_alpha;
		logic        alpha_on;
		logic [8:0]  rot_angle;
		logic [8:0]  start_deg;
		logic [9:0]  end_deg;
		logic [31:0] src_base;
		logic [31:0] dst_base;
		logic [9:0]  src_pitch;
		logic [9:0]  dst_pitch;
		logic [9:0]  dst_width;
	} gagp_params_t;

endpackage

// ==== logic/gagp_regs.sv ====
// Parameter register group of the graphics accelerator, an APB slave.
// Assumes the pixel engine pulses copy_done with the computed edges
// in the same cycle, and that APB inputs are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////
module gagp_regs #(
	parameter int unsigned ADDR_W = 12
) (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [ADDR_W-1:0]     paddr,
	input  wire logic [31:0]           pwdata,
	input  wire logic [3:0]            pstrb,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  copy_done,
	input  wire gagp_pkg::gagp_edges_t copy_edges,
	output gagp_pkg::gagp_params_t     params
);
	import gagp_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Register state
	logic [8:0]  angle_q,       angle_d;
	logic [7:0]  color_q,       color_d;
	logic [15:0] src_lo_q,      src_lo_d;
	logic [15:0] src_hi_q,      src_hi_d;
	logic [15:0] dst_lo_q,      dst_lo_d;
	logic [15:0] dst_hi_q,      dst_hi_d;
	logic [9:0]  src_pitch_q,   src_pitch_d;
	logic [9:0]  dst_pitch_q,   dst_pitch_d;
	logic [9:0]  dst_width_q,   dst_width_d;
	logic [7:0]  ctrl_q,        ctrl_d;
	gagp_edges_t edges_q,       edges_d;
	logic [31:0] rdata_q,       rdata_d;
	gagp_params_t params_q,     params_d;

	logic        wr_en;
	logic        rd_setup;
	logic        addr_hit;
	logic [7:0]  offset;
	logic        lo_lane;
	logic        hi_lane;
	logic [31:0] rd_word;

	////////////////////////////////////////////////////////////////////
	// APB decode
	assign offset   = {paddr[7:2], 2'b00};
	assign wr_en    = psel & penable & pwrite & addr_hit;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign lo_lane  = pstrb[0];
	assign hi_lane  = pstrb[1];

	// Address hit: word aligned, inside the map
	always_comb begin
		addr_hit = 1'b0;
		if (paddr[1:0] == 2'b00 && paddr[ADDR_W-1:8] == '0) begin
			unique case (offset)
				OFF_ROT, OFF_COLOR, OFF_SRC_LO, OFF_SRC_HI,
				OFF_DST_LO, OFF_DST_HI, OFF_SRC_PITCH, OFF_DST_PITCH,
				OFF_LEFT, OFF_RIGHT, OFF_TOP, OFF_BOTTOM,
				OFF_CTRL, OFF_DST_WIDTH: addr_hit = 1'b1;
				default: addr_hit = 1'b0;
			endcase
		end
	end

	// Zero-wait slave; unmapped access answers with an error
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~addr_hit;

	////////////////////////////////////////////////////////////////////
	// Register writes, byte lanes 0 and 1 only
	always_comb begin
		angle_d     = angle_q;
		color_d     = color_q;
		src_lo_d    = src_lo_q;
		src_hi_d    = src_hi_q;
		dst_lo_d    = dst_lo_q;
		dst_hi_d    = dst_hi_q;
		src_pitch_d = src_pitch_q;
		dst_pitch_d = dst_pitch_q;
		dst_width_d = dst_width_q;
		ctrl_d      = ctrl_q;
		if (wr_en) begin
			unique case (offset)
				OFF_ROT: begin
					if (lo_lane) angle_d[7:0] = pwdata[7:0];
					if (hi_lane) angle_d[8] = pwdata[8];
				end
				OFF_COLOR: begin
					if (lo_lane) color_d = pwdata[7:0];
				end
				OFF_SRC_LO: begin
					if (lo_lane) src_lo_d[7:0] = pwdata[7:0];
					if (hi_lane) src_lo_d[15:8] = pwdata[15:8];
				end
				OFF_SRC_HI: begin
					if (lo_lane) src_hi_d[7:0] = pwdata[7:0];
					if (hi_lane) src_hi_d[15:8] = pwdata[15:8];
				end
				OFF_DST_LO: begin
					if (lo_lane) dst_lo_d[7:0] = pwdata[7:0];
					if (hi_lane) dst_lo_d[15:8] = pwdata[15:8];
				end
				OFF_DST_HI: begin
					if (lo_lane) dst_hi_d[7:0] = pwdata[7:0];
					if (hi_lane) dst_hi_d[15:8] = pwdata[15:8];
				end
				OFF_SRC_PITCH: begin
					if (lo_lane) src_pitch_d[7:0] = pwdata[7:0];
					if (hi_lane) src_pitch_d[9:8] = pwdata[9:8];
				end
				OFF_DST_PITCH: begin
					if (lo_lane) dst_pitch_d[7:0] = pwdata[7:0];
					if (hi_lane) dst_pitch_d[9:8] = pwdata[9:8];
				end
				OFF_DST_WIDTH: begin
					if (lo_lane) dst_width_d[7:0] = pwdata[7:0];
					if (hi_lane) dst_width_d[9:8] = pwdata[9:8];
				end
				OFF_CTRL: begin
					if (lo_lane) ctrl_d = pwdata[7:0];
				end
				default: begin
					// Edge registers are read-only and keep their value
				end
			endcase
		end
	end

	// Edge capture: only the copy engine updates these
	always_comb begin
		edges_d = edges_q;
		if (copy_done) begin
			edges_d = copy_edges;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read mux, reserved bits zero
	always_comb begin
		rd_word = 32'h0000_0000;
		unique case (offset)
			OFF_ROT:       rd_word[8:0] = angle_q;
			OFF_COLOR:     rd_word[7:0] = color_q;
			OFF_SRC_LO:    rd_word[15:0] = src_lo_q;
			OFF_SRC_HI:    rd_word[15:0] = src_hi_q;
			OFF_DST_LO:    rd_word[15:0] = dst_lo_q;
			OFF_DST_HI:    rd_word[15:0] = dst_hi_q;
			OFF_SRC_PITCH: rd_word[9:0] = src_pitch_q;
			OFF_DST_PITCH: rd_word[9:0] = dst_pitch_q;
			OFF_LEFT:      rd_word[9:0] = edges_q.left;
			OFF_RIGHT:     rd_word[9:0] = edges_q.right;
			OFF_TOP:       rd_word[9:0] = edges_q.top;
			OFF_BOTTOM:    rd_word[9:0] = edges_q.bottom;
			OFF_DST_WIDTH: rd_word[9:0] = dst_width_q;
			OFF_CTRL: begin
				rd_word[7:0] = ctrl_q;
				rd_word[CTRL_OK_BIT] = (dst_pitch_q >= dst_width_q);
			end
			default:       rd_word = 32'h0000_0000;
		endcase
	end

	// Read data caught in the setup phase
	always_comb begin
		rdata_d = rdata_q;
		if (rd_setup) begin
			rdata_d = addr_hit ? rd_word : 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Engine parameters derived from the next register values
	gagp_func_t  func_n;
	gagp_panel_t panel_n;
	gagp_bpp_t   bpp_n;
	logic        is_copy_n;
	logic [18:0] start_prod;
	logic [19:0] end_prod;

	assign func_n    = gagp_func_t'(ctrl_d[CTRL_FUNC_LSB +: 3]);
	assign panel_n   = gagp_panel_t'(ctrl_d[CTRL_PANEL_LSB +: 2]);
	assign bpp_n     = gagp_bpp_t'(ctrl_d[CTRL_BPP_LSB +: 2]);
	assign is_copy_n = (func_n == FN_ROTATE_SCALE_COPY) || (func_n == FN_SHEAR_COPY);
	// Degree conversion, fraction of a degree dropped
	assign start_prod = 19'({10'h000, angle_d} * 19'(DEG_FULL));
	assign end_prod   = 20'({10'h000, src_pitch_d} * 20'(DEG_FULL));

	always_comb begin
		params_d             = '0;
		params_d.func        = func_n;
		params_d.rot_angle   = angle_d;
		params_d.start_deg   = 9'(start_prod / 19'(ANGLE_STEPS));
		params_d.end_deg     = 10'(end_prod / 20'(ANGLE_STEPS));
		params_d.src_base    = {src_hi_d, src_lo_d};
		params_d.dst_base    = {dst_hi_d, dst_lo_d};
		params_d.src_pitch   = src_pitch_d;
		params_d.dst_pitch   = dst_pitch_d;
		params_d.dst_width   = dst_width_d;
		params_d.fill_active = is_copy_n & ctrl_d[CTRL_FILL_BIT];
		// Pixel value by panel type
		unique case (panel_n)
			PANEL_SERIAL_BW:   params_d.pen_pixel = {7'h00, color_d[0]};
			PANEL_SERIAL_RGB3: params_d.pen_pixel = {5'h00, color_d[2:0]};
			PANEL_RGB6: begin
				params_d.pen_pixel = {2'b00, color_d[5:0]};
				params_d.pen_alpha = color_d[7:6];
				params_d.alpha_on  = ~is_copy_n;
			end
			PANEL_GRAY: begin
				unique case (bpp_n)
					BPP_1: params_d.pen_pixel = {7'h00, color_d[0]};
					BPP_2: params_d.pen_pixel = {6'h00, color_d[1:0]};
					BPP_4: params_d.pen_pixel = {4'h0, color_d[3:0]};
					BPP_8: params_d.pen_pixel = color_d;
				endcase
			end
		endcase
		params_d.fill_color = params_d.fill_active ? params_d.pen_pixel : 8'h00;
	end

	////////////////////////////////////////////////////////////////////
	// State registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			angle_q     <= ROT_RST;
			color_q     <= COLOR_RST;
			src_lo_q    <= HALF_RST;
			src_hi_q    <= HALF_RST;
			dst_lo_q    <= HALF_RST;
			dst_hi_q    <= HALF_RST;
			src_pitch_q <= PITCH_RST;
			dst_pitch_q <= PITCH_RST;
			dst_width_q <= PITCH_RST;
			ctrl_q      <= CTRL_RST;
			edges_q     <= {EDGE_RST, EDGE_RST, EDGE_RST, EDGE_RST};
			rdata_q     <= 32'h0000_0000;
			// Black-and-white panel after reset shows colour bit 0
			params_q           <= '0;
			params_q.pen_pixel <= {7'h00, COLOR_RST[0]};
		end else begin
			angle_q     <= angle_d;
			color_q     <= color_d;
			src_lo_q    <= src_lo_d;
			src_hi_q    <= src_hi_d;
			dst_lo_q    <= dst_lo_d;
			dst_hi_q    <= dst_hi_d;
			src_pitch_q <= src_pitch_d;
			dst_pitch_q <= dst_pitch_d;
			dst_width_q <= dst_width_d;
			ctrl_q      <= ctrl_d;
			edges_q     <= edges_d;
			rdata_q     <= rdata_d;
			params_q    <= params_d;
		end
	end

	assign prdata = rdata_q;
	assign params = params_q;

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	logic wr_any;
	assign wr_any = psel & penable & pwrite;

	rot_write_a: assert property (
		wr_any && offset == OFF_ROT && paddr[1:0] == 2'b00 && paddr[ADDR_W-1:8] == '0
		&& pstrb[1:0] == 2'b11 |=> params.rot_angle == $past(pwdata[8:0]))
		else $error("angle field not taken from write");
	arc_start_a: assert property (
		params.start_deg == 9'((19'({10'h000, params.rot_angle}) * 19'd360) >> 9))
		else $error("arc start degrees wrong");
	arc_end_a: assert property (
		params.end_deg == 10'((20'({10'h000, params.src_pitch}) * 20'd360) >> 9))
		else $error("arc end degrees wrong");
	fill_gate_a: assert property (
		params.fill_active |-> params.func inside {FN_ROTATE_SCALE_COPY, FN_SHEAR_COPY}
		&& params.fill_color == params.pen_pixel)
		else $error("fill colour active outside copy");
	serial_pixel_a: assert property (
		ctrl_q[CTRL_PANEL_LSB +: 2] == PANEL_SERIAL_BW |-> params.pen_pixel == {7'h00, color_q[0]})
		else $error("serial panel pixel wrong");
	rgb6_alpha_a: assert property (
		ctrl_q[CTRL_PANEL_LSB +: 2] == PANEL_RGB6 |-> params.pen_alpha == color_q[7:6]
		&& params.pen_pixel == {2'b00, color_q[5:0]})
		else $error("six-bit colour or alpha wrong");
	gray_mask_a: assert property (
		ctrl_q[CTRL_PANEL_LSB +: 4] == {BPP_4, PANEL_GRAY} |-> params.pen_pixel == {4'h0, color_q[3:0]})
		else $error("grayscale 4 bpp pixel wrong");
	src_base_a: assert property (
		params.src_base == {src_hi_q, src_lo_q})
		else $error("source base halves not joined");
	dst_base_a: assert property (
		wr_any && offset == OFF_DST_HI && addr_hit && pstrb[1:0] == 2'b11
		|=> params.dst_base[31:16] == $past(pwdata[15:0]) && $stable(params.dst_base[15:0]))
		else $error("destination base high half wrong");
	edge_capture_a: assert property (
		copy_done |=> edges_q == $past(copy_edges))
		else $error("edges not captured on copy done");
	edge_ro_a: assert property (
		!copy_done |=> $stable(edges_q))
		else $error("edge register changed without copy");
	rsvd_zero_a: assert property (
		prdata[31:16] == 16'h0000)
		else $error("reserved read bits not zero");

	rgb3_pixel_a: assert property (
		ctrl_q[CTRL_PANEL_LSB +: 2] == PANEL_SERIAL_RGB3
		|-> params.pen_pixel == {5'h00, color_q[2:0]})
		else $error("serial colour panel pixel wrong");
	six_pixel_a: assert property (
		wr_any && addr_hit && offset == OFF_CTRL && pstrb[0]
		&& pwdata[CTRL_PANEL_LSB +: 2] == PANEL_RGB6
		|=> params.pen_pixel == {2'b00, color_q[5:0]})
		else $error("six-bit panel pixel wrong after panel select");
	alpha_draw_a: assert property (
		ctrl_q[CTRL_PANEL_LSB +: 2] == PANEL_RGB6
		|-> params.alpha_on == !(params.func inside {FN_ROTATE_SCALE_COPY, FN_SHEAR_COPY}))
		else $error("alpha blend not limited to drawing");
	src_pitch_a: assert property (
		wr_any && addr_hit && offset == OFF_SRC_PITCH && pstrb[1:0] == 2'b11
		|=> params.src_pitch == $past(pwdata[9:0]))
		else $error("source pitch not taken from write");
	dst_pitch_a: assert property (
		wr_any && addr_hit && offset == OFF_DST_PITCH && pstrb[1:0] == 2'b11
		|=> params.dst_pitch == $past(pwdata[9:0]))
		else $error("destination pitch not taken from write");
	dst_width_a: assert property (
		wr_any && addr_hit && offset == OFF_DST_WIDTH && pstrb[1:0] == 2'b11
		|=> params.dst_width == $past(pwdata[9:0]))
		else $error("destination width not taken from write");
	edge_read_a: assert property (
		rd_setup && addr_hit && offset == OFF_RIGHT
		|=> prdata == {22'h0, $past(edges_q.right)})
		else $error("right edge read wrong");

	cover_copy_c:   cover property (copy_done ##1 rd_setup && offset == OFF_LEFT);
	cover_arc_c:    cover property (params.func == FN_ARC_DRAW_A && params.end_deg > 10'd359);
	cover_alpha_c:  cover property (params.alpha_on && params.pen_alpha == 2'b11);
	cover_err_c:    cover property (pslverr);
	cover_gray_c:   cover property (ctrl_q[CTRL_PANEL_LSB +: 4] == {BPP_8, PANEL_GRAY});

endmodule

`default_nettype wire

// ==== testbench/gagp_regs_tb.sv ====
// Self-checking bench for the accelerator parameter registers.
// Assumes gagp_pkg and gagp_regs are compiled first; the bench is the APB master.
`timescale 1ns/1ps
`default_nettype none

module gagp_regs_tb;
	import gagp_pkg::*;

	logic         clk;
	logic         rst_n;
	logic         psel;
	logic         penable;
	logic         pwrite;
	logic [11:0]  paddr;
	logic [31:0]  pwdata;
	logic [3:0]   pstrb;
	logic [31:0]  prdata;
	logic         pready;
	logic         pslverr;
	logic         copy_done;
	gagp_edges_t  copy_edges;
	gagp_params_t params;
	int           num_errors;
	int           total_checks;
	logic [31:0]  rd_q;
	logic         err_q;
	logic [31:0]  masks [8];
	logic [9:0]   angs [4];
	gagp_edges_t  ev;
	int           i;
	int           j;

	gagp_regs #(.ADDR_W(12)) DUT (
		.clk       (clk),
		.rst_n     (rst_n),
		.psel      (psel),
		.penable   (penable),
		.pwrite    (pwrite),
		.paddr     (paddr),
		.pwdata    (pwdata),
		.pstrb     (pstrb),
		.prdata    (prdata),
		.pready    (pready),
		.pslverr   (pslverr),
		.copy_done (copy_done),
		.copy_edges(copy_edges),
		.params    (params)
	);

	////////////////////////////////////////////////////////////////////////
	// Clock, 10 ns period
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Verdict and end of run
	task automatic give_verdict();
		if (num_errors == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Compare one value
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// One APB transfer, bounded wait on pready
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
		int n;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {4'h0, addr};
		pwdata  <= data;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			num_errors++;
			give_verdict();
		end
		rd_q    = prdata;
		err_q   = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Write, then let outputs settle
	task automatic wr(input logic [7:0] addr, input logic [31:0] data);
		apb(1'b1, addr, data);
		@(negedge clk);
	endtask

	task automatic rd(input string name, input logic [7:0] addr, input logic [31:0] exp);
		apb(1'b0, addr, 32'h0000_0000);
		check(name, rd_q, exp);
	endtask

	// Copy engine completion: raise copy_done with the edges; the caller drops it
	task automatic pulse_copy(input gagp_edges_t e);
		@(posedge clk);
		copy_done  <= 1'b1;
		copy_edges <= e;
	endtask

	// Expected pen pixel per panel and depth
	function automatic logic [7:0] pen_of(input int p, input int b, input logic [7:0] c);
		case (p)
			0: return c & 8'h01;
			1: return c & 8'h07;
			2: return c & 8'h3F;
			default: return c & ((8'h01 << (1 << b)) - 8'h01);
		endcase
	endfunction

	// Read and check all four edge registers, left to bottom
	task automatic rd_edges(input gagp_edges_t e);
		for (int k = 0; k < 4; k++) begin
			rd("edge", OFF_LEFT + 8'(4 * k), {22'h0, 10'(e >> (30 - 10 * k))});
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		rst_n        = 1'b0;
		psel         = 1'b0;
		penable      = 1'b0;
		pwrite       = 1'b0;
		paddr        = 12'h000;
		pwdata       = 32'h0000_0000;
		pstrb        = 4'hF;
		copy_done    = 1'b0;
		copy_edges   = '0;
		num_errors   = 0;
		total_checks = 0;
		masks = '{32'h0000_01FF, 32'h0000_00FF, 32'h0000_FFFF, 32'h0000_FFFF,
			32'h0000_FFFF, 32'h0000_FFFF, 32'h0000_03FF, 32'h0000_03FF};
		angs = '{10'h1FF, 10'h3FF, 10'h080, 10'h100};
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		// Reset values
		for (i = 0; i < 12; i++) begin
			rd("reset value", 8'(i * 4), (i == 1) ? 32'h0000_0003 : 32'h0000_0000);
		end
		check("pen pixel", {24'h0, params.pen_pixel}, 32'h0000_0001);
		// Reserved bits dropped
		for (i = 0; i < 8; i++) begin
			wr(8'(i * 4), 32'hFFFF_FFFF);
			rd("field mask", 8'(i * 4), masks[i]);
		end
		wr(OFF_DST_WIDTH, 32'h0000_FFFF);
		check("dst width", {22'h0, params.dst_width}, 32'h0000_03FF);
		// Base halves
		wr(OFF_SRC_LO, 32'h0000_1234);
		wr(OFF_SRC_HI, 32'hFFFF_ABCD);
		check("src base", params.src_base, 32'hABCD_1234);
		wr(OFF_DST_LO, 32'h0000_5678);
		wr(OFF_DST_HI, 32'h0000_9EF0);
		check("dst base", params.dst_base, 32'h9EF0_5678);
		@(posedge clk);
		pstrb <= 4'h1;
		wr(OFF_SRC_LO, 32'h0000_FFEE);
		@(posedge clk);
		pstrb <= 4'hF;
		rd("byte lane", OFF_SRC_LO, 32'h0000_12EE);
		wr(OFF_DST_PITCH, 32'h0000_0155);
		check("dst pitch", {22'h0, params.dst_pitch}, 32'h0000_0155);
		// Angles and source pitch
		for (i = 0; i < 4; i += 2) begin
			wr(OFF_ROT, {22'h0, angs[i]});
			wr(OFF_SRC_PITCH, {22'h0, angs[i + 1]});
			check("rot angle", {23'h0, params.rot_angle}, {23'h0, angs[i][8:0]});
			check("start deg", {23'h0, params.start_deg}, 32'(angs[i] * 360 / 512));
			check("end deg", {22'h0, params.end_deg}, 32'(angs[i + 1] * 360 / 512));
			check("src pitch", {22'h0, params.src_pitch}, {22'h0, angs[i + 1]});
		end
		// Panel types and grey depths, drawing function
		wr(OFF_COLOR, 32'h0000_FFDB);
		for (i = 0; i < 4; i++) begin
			for (j = 0; j < 4; j++) begin
				wr(OFF_CTRL, {24'h0, 2'(j), 2'(i), 1'b0, 3'h2});
				check("pen pixel", {24'h0, params.pen_pixel}, {24'h0, pen_of(i, j, 8'hDB)});
				check("alpha", {30'h0, params.pen_alpha}, {30'h0, {2{i == 2}}});
				check("alpha on", {31'h0, params.alpha_on}, {31'h0, i == 2});
			end
		end
		// Every function code with fill enabled on six-bit panel
		for (i = 0; i < 8; i++) begin
			wr(OFF_CTRL, {24'h0, 2'h0, 2'h2, 1'b1, 3'(i)});
			check("func", {29'h0, params.func}, 32'(i));
			check("fill on", {31'h0, params.fill_active}, {31'h0, i < 2});
			check("fill col", {24'h0, params.fill_color}, (i < 2) ? 32'h0000_001B : 32'h0);
			check("alpha on", {31'h0, params.alpha_on}, {31'h0, i >= 2});
		end
		rd("ctrl", OFF_CTRL, 32'h0000_002F);
		wr(OFF_DST_WIDTH, 32'h0000_0155);
		rd("pitch ok", OFF_CTRL, 32'h0000_012F);
		// Copy results, back to back
		ev = {10'h3FF, 10'h155, 10'h2AA, 10'h001};
		pulse_copy(ev);
		@(posedge clk);
		copy_done <= 1'b0;
		rd_edges(ev);
		pulse_copy(ev);
		ev = {10'h001, 10'h2AA, 10'h155, 10'h3FF};
		pulse_copy(ev);
		@(posedge clk);
		copy_done <= 1'b0;
		rd_edges(ev);
		// Software cannot change edges
		for (i = 0; i < 4; i++) begin
			wr(OFF_LEFT + 8'(4 * i), 32'hFFFF_FFFF);
		end
		rd_edges(ev);
		// Unmapped and misaligned accesses
		apb(1'b0, 8'h38, 32'h0000_0000);
		check("slverr", {31'h0, err_q}, 32'h0000_0001);
		check("unmapped data", rd_q, 32'h0000_0000);
		apb(1'b1, 8'h02, 32'h0000_0077);
		check("slverr", {31'h0, err_q}, 32'h0000_0001);
		rd("rot kept", OFF_ROT, 32'h0000_0080);
		check("slverr", {31'h0, err_q}, 32'h0000_0000);
		give_verdict();
	end
endmodule

`default_nettype wire
